//--- include/ptu_pkg.sv
// Constants and types of the programmable timer unit
package ptu_pkg;
	// ==========================================================
	// Counter values and the largest rate code
	localparam logic [15:0] WD_COOKIE     = 16'hfade;
	localparam logic [15:0] WD_LAST       = 16'hfffe;
	localparam logic [15:0] PWM_END       = 16'h0001;
	localparam logic [3:0]  RATE_MAX_CODE = 4'hb;

	// ==========================================================
	// Register byte addresses
	localparam logic [31:0] OFS_PWM_HIGH_RELOAD [3] =
		'{32'h700c5000, 32'h700c500c, 32'h700c505c};
	localparam logic [31:0] OFS_PWM_LOW_RELOAD [3] =
		'{32'h700c5004, 32'h700c5010, 32'h700c5060};
	localparam logic [31:0] OFS_PWM_COUNTER [3] =
		'{32'h700c5008, 32'h700c5014, 32'h700c5064};
	localparam logic [31:0] OFS_PRESCALE_SELECT  = 32'h700c5018;
	localparam logic [31:0] OFS_WATCHDOG_COUNTER = 32'h700c501c;
	localparam logic [31:0] OFS_TIMER_STATUS     = 32'h700c5024;
	localparam logic [31:0] OFS_IRQ_ENABLE       = 32'h700c5028;
	localparam logic [31:0] OFS_TIMER_CONTROL    = 32'h700c502c;
	localparam logic [31:0] OFS_INTERVAL_RELOAD [4] =
		'{32'h700c5030, 32'h700c5038, 32'h700c5040, 32'h700c5048};
	localparam logic [31:0] OFS_INTERVAL_COUNTER [4] =
		'{32'h700c5034, 32'h700c503c, 32'h700c5044, 32'h700c504c};

	// ==========================================================
	// Status and enable fields
	localparam int          STS_IT_LSB  = 0;
	localparam int          STS_PWM_LSB = 8;
	localparam int          STS_WD      = 11;

	// ==========================================================
	// Control fields
	localparam int          CTL_PULSE_OUT_ONE_EN     = 0;
	localparam int          CTL_PULSE_OUT_TWO_EN     = 1;
	localparam int          CTL_WD_EN       = 2;
	localparam int          CTL_WD_SPARE    = 3;
	localparam int          CTL_WD_KEEP     = 4;
	localparam int          CTL_WD_CLK32    = 5;
	localparam int          CTL_WD_IRQ_MODE = 8;
	localparam int          CTL_PULSE_OUT_THREE_EN     = 9;
	localparam int          CTL_IT_EN_LSB   = 11;

	// ==========================================================
	// Rate fields
	localparam int          RATE_PWM_LSB = 0;
	localparam int          RATE_WD_LSB  = 4;
	localparam int          RATE_IT_LSB  = 8;

	// ==========================================================
	// Types
	typedef enum logic {PH_HIGH, PH_LOW} ptu_phase_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [31:0] addr;
		logic [31:0] wdata;
	} ptu_bus_req_t;

	typedef struct packed {
		logic [15:0] max;
		logic [15:0] cnt;
	} ptu_it_t;

	typedef struct packed {
		logic [15:0] hi;
		logic [15:0] lo;
		logic [15:0] cnt;
		logic [15:0] lo_latch;
		ptu_phase_t  phase;
		logic        out;
		logic        en_q;
	} ptu_pwm_t;

	typedef struct packed {
		logic [15:0] cnt;
		logic [3:0]  rate;
		logic        en;
		logic        irqm;
		logic        clk32;
		logic        keep;
		logic        spare;
		logic        sts;
	} ptu_wd_t;

	typedef struct packed {
		ptu_it_t [3:0]  it;
		ptu_pwm_t [2:0] pwm;
		ptu_wd_t        wd;
		logic [3:0]     it_en;
		logic [2:0]     pw_en;
		logic [3:0]     it_rate;
		logic [3:0]     pw_rate;
		logic [3:0]     sts_it;
		logic [2:0]     sts_pw;
		logic [11:0]    ie;
		logic [11:0]    pre;
		logic [1:0]     s32;
		logic           s32_q;
		logic           wd_rst;
		logic           wd_cause;
		logic [31:0]    rdata;
		logic           rvalid;
	} ptu_state_t;
endpackage : ptu_pkg

//--- core/ptu_top.sv
// Programmable timer unit: interval timers, watchdog and pulse modulators

module ptu_top (
	// Clock and reset
	input  wire logic                  mclk_in,
	input  wire logic                  rst_b_in,
	// Slow watchdog clock
	input  wire logic                  clk32k_in,
	// Register port
	input  wire ptu_pkg::ptu_bus_req_t bus_req_in,
	output logic [31:0]                bus_rdata_out,
	output logic                       bus_rvalid_out,
	// Events and pins
	output logic                       irq_out,
	output logic                       wd_reset_out,
	output logic                       wd_reset_cause_out,
	output logic                       pulse_out_one_out,
	output logic                       pulse_out_two_out,
	output logic                       pulse_out_three_out
);
	// ==========================================================
	// Helper functions
	function automatic logic wr_hit(input ptu_pkg::ptu_bus_req_t r, input logic [31:0] ofs);
		wr_hit = r.wr && (r.addr == ofs);
	endfunction : wr_hit

	function automatic logic rate_strobe(input logic [11:0] pre, input logic [3:0] code);
		logic [12:0] m;
		m = (13'h0002 << code) - 13'h0001;
		rate_strobe = (code <= ptu_pkg::RATE_MAX_CODE) && ((pre & m[11:0]) == m[11:0]);
	endfunction : rate_strobe

	function automatic ptu_pkg::ptu_pwm_t pwm_start(input ptu_pkg::ptu_pwm_t p);
		pwm_start = p;
		pwm_start.lo_latch = p.lo;
		if (p.hi != 16'h0000) begin
			pwm_start.cnt = p.hi;
			pwm_start.out = 1'b1;
			pwm_start.phase = ptu_pkg::PH_HIGH;
		end else begin
			pwm_start.cnt = p.lo;
			pwm_start.out = 1'b0;
			pwm_start.phase = ptu_pkg::PH_LOW;
		end
	endfunction : pwm_start

	// ==========================================================
	// State and strobes
	ptu_pkg::ptu_state_t s_r;
	ptu_pkg::ptu_state_t s_nxt;
	logic                it_stb;
	logic                pw_stb;
	logic                wd_stb;
	logic                slow_edge;
	logic                cookie;
	logic                wd_tmo;

	assign it_stb = rate_strobe(s_r.pre, s_r.it_rate);
	assign pw_stb = rate_strobe(s_r.pre, s_r.pw_rate);
	assign slow_edge = s_r.s32[1] && !s_r.s32_q;
	assign wd_stb = s_r.wd.clk32 ? slow_edge : rate_strobe(s_r.pre, s_r.wd.rate);
	assign cookie = wr_hit(bus_req_in, ptu_pkg::OFS_WATCHDOG_COUNTER)
		&& (bus_req_in.wdata[15:0] == ptu_pkg::WD_COOKIE);
	assign wd_tmo = s_r.wd.en && wd_stb && (s_r.wd.cnt == ptu_pkg::WD_LAST) && !cookie;

	// ==========================================================
	// Next state
	always_comb begin
		ptu_pkg::ptu_state_t tmp;
		logic [31:0]         rd;
		logic [15:0]         wd16;
		logic                keep;
		tmp = '0;
		rd = '0;
		wd16 = bus_req_in.wdata[15:0];
		keep = s_r.wd.keep && !s_r.wd_rst;
		s_nxt = s_r;
		s_nxt.pre = s_r.pre + 12'h001;
		s_nxt.s32 = {s_r.s32[0], clk32k_in};
		s_nxt.s32_q = s_r.s32[1];
		s_nxt.wd_rst = 1'b0;

		// Status clear, ahead of the events so that a set wins
		if (wr_hit(bus_req_in, ptu_pkg::OFS_TIMER_STATUS)) begin
			s_nxt.sts_it = s_r.sts_it & ~bus_req_in.wdata[ptu_pkg::STS_IT_LSB +: 4];
			s_nxt.sts_pw = s_r.sts_pw & ~bus_req_in.wdata[ptu_pkg::STS_PWM_LSB +: 3];
		end
		if (wr_hit(bus_req_in, ptu_pkg::OFS_IRQ_ENABLE)) begin
			s_nxt.ie = bus_req_in.wdata[11:0] & 12'hf0f;
		end
		if (wr_hit(bus_req_in, ptu_pkg::OFS_PRESCALE_SELECT)) begin
			s_nxt.it_rate = bus_req_in.wdata[ptu_pkg::RATE_IT_LSB +: 4];
			s_nxt.pw_rate = bus_req_in.wdata[ptu_pkg::RATE_PWM_LSB +: 4];
			if (!s_r.wd.en) begin
				s_nxt.wd.rate = bus_req_in.wdata[ptu_pkg::RATE_WD_LSB +: 4];
			end
		end
		if (wr_hit(bus_req_in, ptu_pkg::OFS_TIMER_CONTROL)) begin
			s_nxt.it_en = bus_req_in.wdata[ptu_pkg::CTL_IT_EN_LSB +: 4];
			s_nxt.pw_en[0] = bus_req_in.wdata[ptu_pkg::CTL_PULSE_OUT_ONE_EN];
			s_nxt.pw_en[1] = bus_req_in.wdata[ptu_pkg::CTL_PULSE_OUT_TWO_EN];
			s_nxt.pw_en[2] = bus_req_in.wdata[ptu_pkg::CTL_PULSE_OUT_THREE_EN];
			s_nxt.wd.en = s_r.wd.en | bus_req_in.wdata[ptu_pkg::CTL_WD_EN];
			if (!s_r.wd.en) begin
				s_nxt.wd.irqm = bus_req_in.wdata[ptu_pkg::CTL_WD_IRQ_MODE];
				s_nxt.wd.clk32 = bus_req_in.wdata[ptu_pkg::CTL_WD_CLK32];
				s_nxt.wd.keep = bus_req_in.wdata[ptu_pkg::CTL_WD_KEEP];
				s_nxt.wd.spare = bus_req_in.wdata[ptu_pkg::CTL_WD_SPARE];
			end
		end

		// Interval channels
		for (int i = 0; i < 4; i++) begin
			if (s_r.it_en[i] && it_stb) begin
				if (s_r.it[i].cnt == 16'h0000) begin
					s_nxt.it[i].cnt = s_r.it[i].max;
					s_nxt.sts_it[i] = 1'b1;
				end else begin
					s_nxt.it[i].cnt = s_r.it[i].cnt - 16'h0001;
				end
			end
			if (wr_hit(bus_req_in, ptu_pkg::OFS_INTERVAL_COUNTER[i])) begin
				s_nxt.it[i].cnt = wd16;
			end
			if (wr_hit(bus_req_in, ptu_pkg::OFS_INTERVAL_RELOAD[i])) begin
				s_nxt.it[i].max = wd16;
				s_nxt.it[i].cnt = 16'h0000;
			end
		end

		// Pulse modulator channels
		for (int j = 0; j < 3; j++) begin
			if (s_r.pw_en[j] && !s_r.pwm[j].en_q) begin
				s_nxt.pwm[j] = pwm_start(s_r.pwm[j]);
				s_nxt.sts_pw[j] = 1'b1;
			end else if (s_r.pw_en[j] && pw_stb) begin
				if (s_r.pwm[j].cnt != ptu_pkg::PWM_END) begin
					s_nxt.pwm[j].cnt = s_r.pwm[j].cnt - 16'h0001;
				end else if (s_r.pwm[j].phase == ptu_pkg::PH_HIGH
						&& s_r.pwm[j].lo_latch != 16'h0000) begin
					s_nxt.pwm[j].cnt = s_r.pwm[j].lo_latch;
					s_nxt.pwm[j].out = 1'b0;
					s_nxt.pwm[j].phase = ptu_pkg::PH_LOW;
				end else begin
					s_nxt.pwm[j] = pwm_start(s_r.pwm[j]);
					s_nxt.sts_pw[j] = 1'b1;
				end
			end
			s_nxt.pwm[j].en_q = s_r.pw_en[j];
			if (wr_hit(bus_req_in, ptu_pkg::OFS_PWM_HIGH_RELOAD[j])) begin
				s_nxt.pwm[j].hi = wd16;
			end
			if (wr_hit(bus_req_in, ptu_pkg::OFS_PWM_LOW_RELOAD[j])) begin
				s_nxt.pwm[j].lo = wd16;
			end
			if (wr_hit(bus_req_in, ptu_pkg::OFS_PWM_COUNTER[j])) begin
				s_nxt.pwm[j].cnt = wd16;
			end
		end

		// Watchdog
		if (s_r.wd.en && wd_stb) begin
			s_nxt.wd.cnt = s_r.wd.cnt + 16'h0001;
		end
		if (wr_hit(bus_req_in, ptu_pkg::OFS_WATCHDOG_COUNTER)) begin
			if (!s_r.wd.en) begin
				s_nxt.wd.cnt = wd16;
			end else if (cookie) begin
				s_nxt.wd.cnt = 16'h0000;
				s_nxt.wd.sts = 1'b0;
			end
		end
		if (wd_tmo) begin
			if (s_r.wd.irqm && !s_r.wd.sts) begin
				s_nxt.wd.sts = 1'b1;
			end else begin
				s_nxt.wd_rst = 1'b1;
			end
		end

		// Read data
		for (int i = 0; i < 4; i++) begin
			if (bus_req_in.addr == ptu_pkg::OFS_INTERVAL_RELOAD[i]) begin
				rd[15:0] = s_r.it[i].max;
			end
			if (bus_req_in.addr == ptu_pkg::OFS_INTERVAL_COUNTER[i]) begin
				rd[15:0] = s_r.it[i].cnt;
			end
		end
		for (int j = 0; j < 3; j++) begin
			if (bus_req_in.addr == ptu_pkg::OFS_PWM_HIGH_RELOAD[j]) begin
				rd[15:0] = s_r.pwm[j].hi;
			end
			if (bus_req_in.addr == ptu_pkg::OFS_PWM_LOW_RELOAD[j]) begin
				rd[15:0] = s_r.pwm[j].lo;
			end
			if (bus_req_in.addr == ptu_pkg::OFS_PWM_COUNTER[j]) begin
				rd[15:0] = s_r.pwm[j].cnt;
			end
		end
		if (bus_req_in.addr == ptu_pkg::OFS_WATCHDOG_COUNTER) begin
			rd[15:0] = s_r.wd.cnt;
		end
		if (bus_req_in.addr == ptu_pkg::OFS_PRESCALE_SELECT) begin
			rd[ptu_pkg::RATE_IT_LSB +: 4] = s_r.it_rate;
			rd[ptu_pkg::RATE_WD_LSB +: 4] = s_r.wd.rate;
			rd[ptu_pkg::RATE_PWM_LSB +: 4] = s_r.pw_rate;
		end
		if (bus_req_in.addr == ptu_pkg::OFS_TIMER_STATUS) begin
			rd[ptu_pkg::STS_IT_LSB +: 4] = s_r.sts_it;
			rd[ptu_pkg::STS_PWM_LSB +: 3] = s_r.sts_pw;
			rd[ptu_pkg::STS_WD] = s_r.wd.sts;
		end
		if (bus_req_in.addr == ptu_pkg::OFS_IRQ_ENABLE) begin
			rd[11:0] = s_r.ie;
		end
		if (bus_req_in.addr == ptu_pkg::OFS_TIMER_CONTROL) begin
			rd[ptu_pkg::CTL_IT_EN_LSB +: 4] = s_r.it_en;
			rd[ptu_pkg::CTL_PULSE_OUT_ONE_EN] = s_r.pw_en[0];
			rd[ptu_pkg::CTL_PULSE_OUT_TWO_EN] = s_r.pw_en[1];
			rd[ptu_pkg::CTL_PULSE_OUT_THREE_EN] = s_r.pw_en[2];
			rd[ptu_pkg::CTL_WD_EN] = s_r.wd.en;
			rd[ptu_pkg::CTL_WD_IRQ_MODE] = s_r.wd.irqm;
			rd[ptu_pkg::CTL_WD_CLK32] = s_r.wd.clk32;
			rd[ptu_pkg::CTL_WD_KEEP] = s_r.wd.keep;
			rd[ptu_pkg::CTL_WD_SPARE] = s_r.wd.spare;
		end
		s_nxt.rvalid = bus_req_in.rd;
		s_nxt.rdata = bus_req_in.rd ? rd : 32'h00000000;

		// Reset sources
		if (!rst_b_in || s_r.wd_rst) begin
			tmp = s_nxt;
			s_nxt = '0;
			if (keep) begin
				s_nxt.wd = tmp.wd;
				s_nxt.wd_rst = tmp.wd_rst;
			end
			s_nxt.wd_cause = s_r.wd_rst;
			s_nxt.s32 = tmp.s32;
			s_nxt.s32_q = tmp.s32_q;
		end
	end

	always_ff @(posedge mclk_in) begin
		s_r <= s_nxt;
	end

	// ==========================================================
	// Outputs
	assign bus_rdata_out = s_r.rdata;
	assign bus_rvalid_out = s_r.rvalid;
	assign irq_out = |(s_r.sts_it & s_r.ie[ptu_pkg::STS_IT_LSB +: 4])
		| |(s_r.sts_pw & s_r.ie[ptu_pkg::STS_PWM_LSB +: 3])
		| (s_r.wd.sts & s_r.ie[ptu_pkg::STS_WD]);
	assign wd_reset_out = s_r.wd_rst;
	assign wd_reset_cause_out = s_r.wd_cause;
	assign pulse_out_one_out = s_r.pwm[0].out;
	assign pulse_out_two_out = s_r.pwm[1].out;
	assign pulse_out_three_out = s_r.pwm[2].out;

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rst_b_in);

	a_it_reload_flag: assert property (
		(s_r.it_en[0] && it_stb && s_r.it[0].cnt == 16'h0000 && !s_r.wd_rst
			&& !wr_hit(bus_req_in, ptu_pkg::OFS_INTERVAL_COUNTER[0])
			&& !wr_hit(bus_req_in, ptu_pkg::OFS_INTERVAL_RELOAD[0]))
		|=> (s_r.it[0].cnt == $past(s_r.it[0].max)) && s_r.sts_it[0])
		else $error("interval reload or flag missing");
	a_it_zero_keep: assert property (
		(wr_hit(bus_req_in, ptu_pkg::OFS_TIMER_STATUS) && !bus_req_in.wdata[0]
			&& s_r.sts_it[0] && !s_r.wd_rst) |=> s_r.sts_it[0])
		else $error("interval flag lost on zero write");
	a_irq_from_it: assert property (
		(s_r.sts_it[0] && s_r.ie[0]) |-> irq_out)
		else $error("interrupt not raised");
	a_reload_clears: assert property (
		(wr_hit(bus_req_in, ptu_pkg::OFS_INTERVAL_RELOAD[1]) && !s_r.wd_rst)
		|=> s_r.it[1].cnt == 16'h0000)
		else $error("reload write did not clear count");
	a_rate_reserved: assert property (
		(s_r.it_rate > ptu_pkg::RATE_MAX_CODE) |-> !it_stb)
		else $error("strobe on reserved rate");
	a_it_idle_hold: assert property (
		(!s_r.it_en[0] && !s_r.wd_rst
			&& !wr_hit(bus_req_in, ptu_pkg::OFS_INTERVAL_COUNTER[0])
			&& !wr_hit(bus_req_in, ptu_pkg::OFS_INTERVAL_RELOAD[0]))
		|=> $stable(s_r.it[0].cnt))
		else $error("disabled interval count moved");
	a_wd_cookie_clear: assert property (
		(s_r.wd.en && cookie && !s_r.wd_rst) |=> s_r.wd.cnt == 16'h0000)
		else $error("cookie did not clear watchdog");
	a_wd_all_ones: assert property (
		(wd_tmo && !s_r.wd_rst) |=> s_r.wd.cnt == 16'hffff)
		else $error("time-out not at all ones");
	a_wd_second_tmo: assert property (
		(wd_tmo && s_r.wd.irqm && s_r.wd.sts) |=> wd_reset_out ##1 !wd_reset_out)
		else $error("second time-out did not reset");
	a_wd_direct_rst: assert property (
		(wd_tmo && !s_r.wd.irqm) |=> wd_reset_out)
		else $error("time-out did not reset");
	a_wd_en_sticky: assert property (
		(s_r.wd.en && !s_r.wd_rst) |=> s_r.wd.en && $stable(s_r.wd.rate))
		else $error("watchdog enable or rate changed");
	a_wd_slow_clock: assert property (
		(s_r.wd.en && s_r.wd.clk32 && !slow_edge && !s_r.wd_rst
			&& !wr_hit(bus_req_in, ptu_pkg::OFS_WATCHDOG_COUNTER))
		|=> $stable(s_r.wd.cnt))
		else $error("watchdog moved without slow edge");
	a_pwm_restart: assert property (
		(s_r.pw_en[0] && !s_r.pwm[0].en_q && s_r.pwm[0].hi != 16'h0000 && !s_r.wd_rst
			&& !wr_hit(bus_req_in, ptu_pkg::OFS_PWM_COUNTER[0]))
		|=> pulse_out_one_out && s_r.pwm[0].cnt == $past(s_r.pwm[0].hi))
		else $error("modulator did not restart on A");
	a_pwm_hold_out: assert property (
		(!s_r.pw_en[0] && !s_r.wd_rst) |=> $stable(pulse_out_one_out))
		else $error("disabled modulator output moved");
	a_strobe_single: assert property (
		(pw_stb && !wr_hit(bus_req_in, ptu_pkg::OFS_PRESCALE_SELECT) && !s_r.wd_rst)
		|=> !pw_stb)
		else $error("strobe longer than one cycle");
	a_it_count_down: assert property (
		(s_r.it_en[0] && it_stb && s_r.it[0].cnt != 16'h0000 && !s_r.wd_rst
			&& !wr_hit(bus_req_in, ptu_pkg::OFS_INTERVAL_COUNTER[0])
			&& !wr_hit(bus_req_in, ptu_pkg::OFS_INTERVAL_RELOAD[0]))
		|=> s_r.it[0].cnt == $past(s_r.it[0].cnt) - 16'h0001)
		else $error("interval count did not decrement");
	a_wd_irq_flag: assert property (
		(wd_tmo && s_r.wd.irqm && !s_r.wd.sts && !s_r.wd_rst) |=> s_r.wd.sts && !wd_reset_out)
		else $error("first time-out did not set flag");
	a_pwm_low_phase: assert property (
		(s_r.pw_en[0] && s_r.pwm[0].en_q && pw_stb && s_r.pwm[0].phase == ptu_pkg::PH_HIGH
			&& s_r.pwm[0].cnt == ptu_pkg::PWM_END && s_r.pwm[0].lo_latch != 16'h0000
			&& !s_r.wd_rst && !wr_hit(bus_req_in, ptu_pkg::OFS_PWM_COUNTER[0]))
		|=> !pulse_out_one_out && s_r.pwm[0].cnt == $past(s_r.pwm[0].lo_latch))
		else $error("modulator did not enter B count");
	a_pwm_flag_start: assert property (
		(s_r.pw_en[0] && !s_r.pwm[0].en_q && !s_r.wd_rst) |=> s_r.sts_pw[0])
		else $error("modulator start flag missing");
	a_wd_cause_set: assert property (
		s_r.wd_rst |=> wd_reset_cause_out)
		else $error("reset cause not recorded");
	a_wd_ctl_locked: assert property (
		(s_r.wd.en && !s_r.wd_rst) |=> $stable(s_r.wd.irqm) && $stable(s_r.wd.clk32))
		else $error("locked watchdog control changed");
endmodule : ptu_top

//--- verif/test_ptu_top.sv
// Self-checking testbench of the programmable timer unit
module test_ptu_top;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [31:0] data;
		logic [31:0] mask;
	} ptu_exp_t;

	// ==========================================================
	// Signals
	logic                  mclk_in;
	logic                  rst_b_in;
	logic                  clk32k_in;
	ptu_pkg::ptu_bus_req_t bus_req;
	logic [31:0]           bus_rdata;
	logic                  bus_rvalid;
	logic                  irq;
	logic                  wd_reset;
	logic                  wd_cause;
	logic [2:0]            pulse;
	ptu_exp_t              exp_q[$];
	int                    error_cnt = 0;
	int                    comparisons = 0;
	int                    seed;
	int                    cyc = 0;

	// ==========================================================
	// Design
	ptu_top dut_u (
		.mclk_in             (mclk_in),
		.rst_b_in            (rst_b_in),
		.clk32k_in           (clk32k_in),
		.bus_req_in          (bus_req),
		.bus_rdata_out       (bus_rdata),
		.bus_rvalid_out      (bus_rvalid),
		.irq_out             (irq),
		.wd_reset_out        (wd_reset),
		.wd_reset_cause_out  (wd_cause),
		.pulse_out_one_out   (pulse[0]),
		.pulse_out_two_out   (pulse[1]),
		.pulse_out_three_out (pulse[2])
	);

	// ==========================================================
	// Clocks
	initial begin
		mclk_in = 1'b0;
		forever #2 mclk_in = ~mclk_in;
	end

	initial begin
		clk32k_in = 1'b0;
		forever #2000 clk32k_in = ~clk32k_in;
	end

	always @(posedge mclk_in) begin
		cyc <= cyc + 1;
	end

	// ==========================================================
	// Checking and ending
	task automatic fail(input string msg);
		error_cnt++;
		$display("mismatch at %0t: %s", $time, msg);
	endtask : fail

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
		comparisons++;
		if (got !== exp) begin
			fail($sformatf("%s got %h expected %h", msg, got, exp));
		end
	endtask : check

	task automatic check_rd(input logic [31:0] got, input ptu_exp_t e);
		check(got & e.mask, e.data & e.mask, "read data");
	endtask : check_rd

	task automatic stop_test();
		$display("counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : stop_test

	// Read answers are taken off the queue as they appear
	always @(posedge mclk_in) begin
		if (bus_rvalid === 1'b1) begin
			if (exp_q.size() == 0) begin
				fail("read answer without request");
			end else begin
				check_rd(bus_rdata, exp_q.pop_front());
			end
		end
	end

	// ==========================================================
	// Drivers
	task automatic do_reset();
		@(posedge mclk_in);
		#1;
		rst_b_in = 1'b0;
		repeat (20) @(posedge mclk_in);
		#1;
		rst_b_in = 1'b1;
	endtask : do_reset

	task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		#1;
		bus_req.wr = 1'b1;
		bus_req.addr = a;
		bus_req.wdata = d;
		@(posedge mclk_in);
		#1;
		bus_req.wr = 1'b0;
	endtask : bus_wr

	task automatic bus_rd(input logic [31:0] a, input logic [31:0] d, input logic [31:0] m);
		@(posedge mclk_in);
		#1;
		bus_req.rd = 1'b1;
		bus_req.addr = a;
		exp_q.push_back('{data: d, mask: m});
		@(posedge mclk_in);
		#1;
		bus_req.rd = 1'b0;
	endtask : bus_rd

	function automatic logic pick(input int s);
		case (s)
			0: return irq;
			1: return wd_reset;
			5: return clk32k_in;
			default: return pulse[s-2];
		endcase
	endfunction : pick

	task automatic wait_for(input int s, input logic lvl, input int bound);
		int n;
		n = 0;
		while (pick(s) !== lvl) begin
			@(negedge mclk_in);
			n++;
			if (n > bound) begin
				fail("wait ran out");
				stop_test();
			end
		end
	endtask : wait_for

	// Interval flag spacing of channel 0 at one rate code and reload value
	task automatic it_period(input int code, input int n);
		int t1;
		bus_wr(ptu_pkg::OFS_PRESCALE_SELECT, 32'(code << 8));
		bus_wr(ptu_pkg::OFS_INTERVAL_RELOAD[0], 32'(n));
		bus_wr(ptu_pkg::OFS_IRQ_ENABLE, 32'h1);
		bus_wr(ptu_pkg::OFS_TIMER_CONTROL, 32'h800);
		wait_for(0, 1'b1, 20000);
		t1 = cyc;
		bus_wr(ptu_pkg::OFS_TIMER_STATUS, 32'h1);
		wait_for(0, 1'b1, 20000);
		check(32'(cyc - t1), 32'((n + 1) << (code + 1)), "interval period");
		bus_wr(ptu_pkg::OFS_TIMER_STATUS, 32'h0);
		check(irq, 32'h1, "flag kept by zero write");
		bus_wr(ptu_pkg::OFS_TIMER_CONTROL, 32'h0);
		bus_wr(ptu_pkg::OFS_TIMER_STATUS, 32'h1);
		check(irq, 32'h0, "flag cleared by one write");
	endtask : it_period

	// ==========================================================
	// Main sequence
	initial begin
		int v;
		int a1;
		int b1;
		int hi[3];
		int t0;
		bus_req = '0;
		rst_b_in = 1'b0;
		seed = 32;
		do_reset();
		bus_wr(32'h700c5020, 32'hffffffff);
		bus_rd(32'h700c5020, 32'h0, 32'hffffffff);
		v = $random(seed) & 32'hffff;
		bus_wr(ptu_pkg::OFS_INTERVAL_RELOAD[1], 32'(v));
		bus_rd(ptu_pkg::OFS_INTERVAL_RELOAD[1], 32'(v), 32'hffffffff);
		bus_rd(ptu_pkg::OFS_INTERVAL_COUNTER[1], 32'h0, 32'hffffffff);
		$display("test registers done");
		for (int k = 0; k <= 11; k++) begin
			it_period(k, 1);
		end
		it_period(0, 2 + ($random(seed) & 7));
		bus_wr(ptu_pkg::OFS_INTERVAL_COUNTER[0], 32'habc);
		repeat (20) @(posedge mclk_in);
		bus_rd(ptu_pkg::OFS_INTERVAL_COUNTER[0], 32'habc, 32'hffffffff);
		bus_wr(ptu_pkg::OFS_PRESCALE_SELECT, 32'hf00);
		bus_wr(ptu_pkg::OFS_TIMER_CONTROL, 32'h800);
		repeat (4100) @(posedge mclk_in);
		bus_rd(ptu_pkg::OFS_INTERVAL_COUNTER[0], 32'habc, 32'hffffffff);
		bus_wr(ptu_pkg::OFS_TIMER_CONTROL, 32'h0);
		$display("test interval done");
		v = $random(seed) & 32'hffff;
		bus_wr(ptu_pkg::OFS_WATCHDOG_COUNTER, 32'(v));
		bus_rd(ptu_pkg::OFS_WATCHDOG_COUNTER, 32'(v), 32'hffffffff);
		bus_wr(ptu_pkg::OFS_PRESCALE_SELECT, 32'h30);
		bus_wr(ptu_pkg::OFS_WATCHDOG_COUNTER, 32'hfff8);
		bus_wr(ptu_pkg::OFS_IRQ_ENABLE, 32'h800);
		bus_wr(ptu_pkg::OFS_TIMER_CONTROL, 32'h104);
		bus_wr(ptu_pkg::OFS_WATCHDOG_COUNTER, 32'h0);
		bus_rd(ptu_pkg::OFS_WATCHDOG_COUNTER, 32'hfff0, 32'hfff0);
		bus_wr(ptu_pkg::OFS_TIMER_CONTROL, 32'h0);
		bus_rd(ptu_pkg::OFS_TIMER_CONTROL, 32'h104, 32'hffffffff);
		bus_wr(ptu_pkg::OFS_PRESCALE_SELECT, 32'h0);
		bus_rd(ptu_pkg::OFS_PRESCALE_SELECT, 32'h30, 32'hffffffff);
		wait_for(0, 1'b1, 300);
		check(wd_cause, 32'h0, "no reset on first time-out");
		bus_wr(ptu_pkg::OFS_WATCHDOG_COUNTER, 32'(ptu_pkg::WD_COOKIE));
		check(irq, 32'h0, "cookie clears watchdog flag");
		bus_rd(ptu_pkg::OFS_WATCHDOG_COUNTER, 32'h0, 32'hfffe);
		do_reset();
		bus_rd(ptu_pkg::OFS_TIMER_CONTROL, 32'h0, 32'hffffffff);
		bus_wr(ptu_pkg::OFS_WATCHDOG_COUNTER, 32'hfff0);
		bus_wr(ptu_pkg::OFS_TIMER_CONTROL, 32'h4);
		wait_for(1, 1'b1, 100);
		repeat (2) @(negedge mclk_in);
		check(wd_cause, 32'h1, "reset cause after watchdog reset");
		bus_rd(ptu_pkg::OFS_TIMER_CONTROL, 32'h0, 32'hffffffff);
		bus_wr(ptu_pkg::OFS_TIMER_CONTROL, 32'h10);
		bus_wr(ptu_pkg::OFS_WATCHDOG_COUNTER, 32'h1234);
		do_reset();
		check(wd_cause, 32'h0, "cause cleared by external reset");
		bus_rd(ptu_pkg::OFS_WATCHDOG_COUNTER, 32'h1234, 32'hffffffff);
		bus_rd(ptu_pkg::OFS_TIMER_CONTROL, 32'h10, 32'hffffffff);
		$display("test watchdog done");
		a1 = 1 + ($random(seed) & 7);
		b1 = 1 + ($random(seed) & 7);
		bus_wr(ptu_pkg::OFS_PWM_HIGH_RELOAD[0], 32'(a1));
		bus_wr(ptu_pkg::OFS_PWM_LOW_RELOAD[0], 32'(b1));
		bus_wr(ptu_pkg::OFS_PWM_HIGH_RELOAD[1], 32'h3);
		bus_wr(ptu_pkg::OFS_PWM_LOW_RELOAD[1], 32'h0);
		bus_wr(ptu_pkg::OFS_PWM_HIGH_RELOAD[2], 32'h0);
		bus_wr(ptu_pkg::OFS_PWM_LOW_RELOAD[2], 32'h4);
		bus_wr(ptu_pkg::OFS_IRQ_ENABLE, 32'h100);
		bus_wr(ptu_pkg::OFS_TIMER_CONTROL, 32'h203);
		wait_for(0, 1'b1, 100);
		repeat (40) @(negedge mclk_in);
		hi = '{0, 0, 0};
		repeat (8 * (a1 + b1)) begin
			@(negedge mclk_in);
			for (int i = 0; i < 3; i++) begin
				hi[i] += int'(pulse[i]);
			end
		end
		check(32'(hi[0]), 32'(8 * a1), "high time of first channel");
		check(32'(hi[1]), 32'(8 * (a1 + b1)), "zero low value stays high");
		check(32'(hi[2]), 32'h0, "zero high value stays low");
		bus_wr(ptu_pkg::OFS_TIMER_CONTROL, 32'h0);
		repeat (2) @(negedge mclk_in);
		v = 32'(pulse);
		repeat (30) @(negedge mclk_in);
		check(32'(pulse), 32'(v), "disabled outputs hold");
		bus_wr(ptu_pkg::OFS_PWM_HIGH_RELOAD[2], 32'h6);
		bus_wr(ptu_pkg::OFS_TIMER_CONTROL, 32'h200);
		wait_for(4, 1'b1, 4);
		$display("test modulator done");
		wait_for(5, 1'b1, 1200);
		wait_for(5, 1'b0, 600);
		t0 = cyc;
		bus_wr(ptu_pkg::OFS_WATCHDOG_COUNTER, 32'hfffe);
		bus_wr(ptu_pkg::OFS_TIMER_CONTROL, 32'h20);
		bus_wr(ptu_pkg::OFS_TIMER_CONTROL, 32'h24);
		wait_for(1, 1'b1, 700);
		check(32'((cyc - t0) inside {[495:510]}), 32'h1, "watchdog paced by slow clock");
		$display("test slow clock done");
		repeat (5) @(posedge mclk_in);
		check(32'(exp_q.size()), 32'h0, "reads left unanswered");
		stop_test();
	end
endmodule : test_ptu_top
